// File: hdl/bvcs_defines.svh
`ifndef BVCS_DEFINES_SVH
`define BVCS_DEFINES_SVH

// Register offsets, 12-bit word addresses
`define BVCS_OFS_BUS_OPTION      12'h706
`define BVCS_OFS_OV_THRESHOLD    12'h707
`define BVCS_OFS_RT_ACTION       12'h708
`define BVCS_OFS_RT_RECOVERY     12'h709
`define BVCS_OFS_RT_CHECK_TIME   12'h70a
`define BVCS_OFS_CL_SELECT       12'h70b
`define BVCS_OFS_CL_LEVEL        12'h70c
`define BVCS_OFS_QUICK_CL_SELECT 12'h70d
`define BVCS_OFS_RT_DECEL_TIME   12'h71e
`define BVCS_OFS_HF_COMP         12'h7f0
`define BVCS_OFS_OV_BOOST_CEIL   12'h7f1
`define BVCS_OFS_FW_PROP_GAIN    12'h7f2
`define BVCS_OFS_FW_INT_TIME     12'h7f3
`define BVCS_OFS_RAMP_TIME       12'h7f4
`define BVCS_OFS_STATUS          12'h7f8
`define BVCS_OFS_FREQ_OUT        12'h7f9

// Reset values (0.1 % units, 0.1 s, 0.01 s, 0.01 gain)
`define BVCS_RST_BUS_OPTION      16'h000a
`define BVCS_RST_OV_THRESHOLD    16'h053d
`define BVCS_RST_RT_ACTION       16'h02f8
`define BVCS_RST_RT_RECOVERY     16'h035c
`define BVCS_RST_RT_CHECK_TIME   16'h0005
`define BVCS_RST_CL_SELECT       16'h0002
`define BVCS_RST_CL_LEVEL        16'h05dc
`define BVCS_RST_QUICK_CL_SELECT 16'h0000
`define BVCS_RST_RT_DECEL_TIME   16'h07d0
`define BVCS_RST_HF_COMP         16'h01f4
`define BVCS_RST_OV_BOOST_CEIL   16'h0064
`define BVCS_RST_FW_PROP_GAIN    16'h000f
`define BVCS_RST_FW_INT_TIME     16'h03e8
`define BVCS_RST_RAMP_TIME       16'h03e8

// Field values and limits
`define BVCS_OPTION_TENS         16'h000a
`define BVCS_OPTION_MAX          16'h000c
`define BVCS_HF_COMP_NEUTRAL     16'h01f4
`define BVCS_PERMILLE_FULL       16'h03e8
`define BVCS_BASE_PROP_GAIN      16'h0014
`define BVCS_BASE_INT_TIME       16'h03e8

// Timing
`define BVCS_CLK_MHZ             100
`define BVCS_TICK_US             1000
`define BVCS_TICKS_PER_CENTISEC  (10000 / `BVCS_TICK_US)
`define BVCS_TICKS_PER_DECISEC   (100000 / `BVCS_TICK_US)

`endif

// File: hdl/bvcs_pkg.sv
`default_nettype none
package bvcs_pkg;

  typedef enum logic [1:0] {
    st_normal   = 2'b00,
    st_rt_decel = 2'b01,
    st_rt_hold  = 2'b10,
    st_rt_stop  = 2'b11
  } ride_state_type;

  typedef struct packed {
    logic [15:0] bus_option;
    logic [15:0] ov_threshold;
    logic [15:0] rt_action;
    logic [15:0] rt_recovery;
    logic [15:0] rt_check_time;
    logic [15:0] cl_select;
    logic [15:0] cl_level;
    logic [15:0] quick_cl_select;
    logic [15:0] rt_decel_time;
    logic [15:0] hf_comp;
    logic [15:0] ov_boost_ceil;
    logic [15:0] fw_prop_gain;
    logic [15:0] fw_int_time;
    logic [15:0] ramp_time;
  } regs_type;

  typedef struct packed {
    regs_type       regs;
    ride_state_type state;
    logic [15:0]    freq;
    logic [31:0]    ramp_acc;
    logic [31:0]    integ;
    logic [31:0]    tick_cnt;
    logic [31:0]    rec_cnt;
    logic [15:0]    stall_base;
    logic           tick;
    logic           ov_hit;
    logic           below_action;
    logic           above_recovery;
    logic           cl_hit;
    logic [15:0]    cl_excess;
    logic           power_down;
    logic           ov_active;
    logic           cl_active;
    logic [15:0]    rdata;
  } ctrl_type;

endpackage : bvcs_pkg
`default_nettype wire

// File: hdl/bus_voltage_current_stall_ctrl.sv
// Implementation choice: the strobed register port.
`include "bvcs_defines.svh"
`default_nettype none

module bus_voltage_current_stall_ctrl #(
  parameter int          TICK_CYCLES = `BVCS_TICK_US * `BVCS_CLK_MHZ,
  parameter logic [15:0] FREQ_MAX    = 16'h1388
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Measurements and reference
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] out_current,
  input  wire logic [15:0] freq_ref,
  input  wire logic        run_cmd,
  input  wire logic        vf_mode,
  input  wire logic        field_weak,
  // Modulator side
  output logic      [15:0] freq_out,
  output logic             power_down,
  output logic             ov_stall_active,
  output logic             cur_limit_active,
  output logic             quick_cl_enable
);

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
    if (FREQ_MAX == 16'h0000) begin : g_bad_fmax
      $error("FREQ_MAX must be non-zero");
    end
  endgenerate

  bvcs_pkg::ctrl_type q;
  bvcs_pkg::ctrl_type d;

  function automatic logic [15:0] clampw(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clampw = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampw

  logic        ov_en;
  logic [15:0] rt_mode;
  logic [1:0]  cl_mode;
  logic        cl_en;
  logic [15:0] target;
  logic [31:0] ramp_ticks;
  logic [31:0] rec_ticks;
  logic [31:0] cur_scaled;
  logic [31:0] lvl_scaled;
  logic [31:0] boost_lim;
  logic [31:0] pi_step;
  logic [31:0] cl_step;
  logic [31:0] int_ticks;
  logic [15:0] kp;
  logic [15:0] ki_time;

  always_comb begin
    // Option is held as its decimal value, so tens digit 1 means 10 and up
    ov_en   = (q.regs.bus_option >= `BVCS_OPTION_TENS);
    rt_mode = ov_en ? q.regs.bus_option - `BVCS_OPTION_TENS : q.regs.bus_option;
    cl_mode = q.regs.cl_select[1:0];
    cl_en   = (cl_mode != 2'b00) && vf_mode;
    kp      = field_weak ? q.regs.fw_prop_gain : `BVCS_BASE_PROP_GAIN;
    ki_time = field_weak ? q.regs.fw_int_time : `BVCS_BASE_INT_TIME;
    // Field weakening compares current*coef against level*neutral, avoiding a divider
    cur_scaled = field_weak ? 32'(out_current) * 32'(q.regs.hf_comp)
                            : 32'(out_current) * 32'(`BVCS_HF_COMP_NEUTRAL);
    lvl_scaled = 32'(q.regs.cl_level) * 32'(`BVCS_HF_COMP_NEUTRAL);
    boost_lim  = 32'(q.stall_base)
                 + ((32'(q.stall_base) * 32'(q.regs.ov_boost_ceil)) >> 10);
    pi_step    = (32'(q.cl_excess) * 32'(kp)) >> 7;
    int_ticks  = 32'(ki_time) * 32'(`BVCS_TICKS_PER_CENTISEC);
    rec_ticks  = 32'(q.regs.rt_check_time) * 32'(`BVCS_TICKS_PER_DECISEC);
    if (q.state == bvcs_pkg::st_normal) begin
      target     = run_cmd ? ((freq_ref > FREQ_MAX) ? FREQ_MAX : freq_ref) : 16'h0000;
      ramp_ticks = 32'(q.regs.ramp_time) * 32'(`BVCS_TICKS_PER_CENTISEC);
    end else if (q.state == bvcs_pkg::st_rt_hold) begin
      target     = q.freq;
      ramp_ticks = 32'(q.regs.rt_decel_time) * 32'(`BVCS_TICKS_PER_CENTISEC);
    end else begin
      target     = 16'h0000;
      ramp_ticks = 32'(q.regs.rt_decel_time) * 32'(`BVCS_TICKS_PER_CENTISEC);
    end
  end

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    // Mode 2 removes at least one step per tick, so even a small excess acts
    cl_step = pi_step;
    // Control tick divider
    if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      d.tick_cnt = 32'h0000_0000;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h0000_0001;
    end

    // Sampled comparisons, refreshed once per tick
    if (q.tick) begin
      d.ov_hit         = ov_en && (bus_voltage > q.regs.ov_threshold);
      d.below_action   = bus_voltage < q.regs.rt_action;
      d.above_recovery = bus_voltage > q.regs.rt_recovery;
      d.cl_hit         = cl_en && run_cmd
                         && (q.freq != 16'h0000)
                         && (cur_scaled >= lvl_scaled);
      d.cl_excess      = (out_current > q.regs.cl_level) ? out_current - q.regs.cl_level : 16'h0000;
    end

    // Power-down status and recovery timer
    // Any dip below the action voltage restarts the recovery wait from zero
    if (q.below_action) begin
      d.power_down = 1'b1;
      d.rec_cnt    = 32'h0000_0000;
    end else if (q.power_down && q.above_recovery) begin
      if (d.tick) begin
        d.rec_cnt = q.rec_cnt + 32'h0000_0001;
      end
      if (q.rec_cnt >= rec_ticks) begin
        d.power_down = 1'b0;
        d.rec_cnt    = 32'h0000_0000;
      end
    end else begin
      d.rec_cnt = 32'h0000_0000;
    end

    // Ride-through sequence
    case (q.state)
      bvcs_pkg::st_normal: begin
        if (q.below_action && run_cmd && rt_mode == 16'h0001) begin
          d.state = bvcs_pkg::st_rt_decel;
        end else if (q.below_action && run_cmd && rt_mode == 16'h0002) begin
          d.state = bvcs_pkg::st_rt_stop;
        end
      end
      bvcs_pkg::st_rt_decel: begin
        // Between action and recovery voltage the slowdown carries on
        if (q.above_recovery) begin
          d.state = bvcs_pkg::st_rt_hold;
        end
      end
      bvcs_pkg::st_rt_hold: begin
        if (q.below_action) begin
          d.state = bvcs_pkg::st_rt_decel;
        end else if (!q.power_down) begin
          d.state = bvcs_pkg::st_normal;
        end
      end
      bvcs_pkg::st_rt_stop: begin
        // Stays at zero until run is withdrawn, whatever the bus does
        if (!run_cmd && q.freq == 16'h0000) begin
          d.state = bvcs_pkg::st_normal;
        end
      end
      default: d.state = bvcs_pkg::st_normal;
    endcase

    // Frequency ramp
    d.ov_active = q.ov_hit && (target < q.freq || q.ov_active);
    d.cl_active = q.cl_hit;
    // Boost ceiling is measured from the frequency held when the stall began
    if (!q.ov_active) begin
      d.stall_base = q.freq;
    end
    // Current limit outranks the stall hold, as holding speed would let current climb
    if (q.cl_hit) begin
      // Current limit overrides the ramp; releasing it resumes the normal target
      d.ramp_acc = 32'h0000_0000;
      if (q.tick) begin
        if (cl_mode == 2'b01) begin
          d.freq = (q.freq != 16'h0000) ? q.freq - 16'h0001 : 16'h0000;
        end else begin
          d.integ = q.integ + 32'(q.cl_excess);
          if (q.integ >= int_ticks) begin
            d.integ = 32'h0000_0000;
            cl_step = pi_step + 32'h0000_0001;
          end
          if (cl_step == 32'h0000_0000) begin
            cl_step = 32'h0000_0001;
          end
          d.freq = (32'(q.freq) > cl_step) ? q.freq - cl_step[15:0] : 16'h0000;
        end
      end
    end else if (q.ov_active && q.state == bvcs_pkg::st_normal) begin
      // Hold deceleration; a small rise is allowed to bleed regenerated energy
      d.ramp_acc = 32'h0000_0000;
      d.integ    = 32'h0000_0000;
      if (q.tick && 32'(q.freq) < boost_lim && q.freq < FREQ_MAX) begin
        d.freq = q.freq + 16'h0001;
      end
    end else begin
      d.integ = 32'h0000_0000;
      if (target == q.freq) begin
        d.ramp_acc = 32'h0000_0000;
      end else if (ramp_ticks == 32'h0000_0000) begin
        d.freq     = target;
        d.ramp_acc = 32'h0000_0000;
      end else begin
        if (q.tick) begin
          d.ramp_acc = q.ramp_acc + 32'(FREQ_MAX);
        end
        if (q.ramp_acc >= ramp_ticks) begin
          d.ramp_acc = d.ramp_acc - ramp_ticks;
          d.freq     = (target > q.freq) ? q.freq + 16'h0001 : q.freq - 16'h0001;
        end
      end
    end

    // Register writes: bus option drops invalid values, action/recovery/check/ramp times are stored unclamped, the rest are clamped
    if (reg_write) begin
      if (reg_addr == `BVCS_OFS_BUS_OPTION) begin
        if (reg_wdata <= `BVCS_OPTION_MAX && (reg_wdata < 16'h0003 || reg_wdata >= `BVCS_OPTION_TENS)) begin
          d.regs.bus_option = reg_wdata;
        end
      end else if (reg_addr == `BVCS_OFS_OV_THRESHOLD) begin
        d.regs.ov_threshold = clampw(reg_wdata, 16'h044c, 16'h05dc);
      end else if (reg_addr == `BVCS_OFS_RT_ACTION) begin
        d.regs.rt_action = reg_wdata;
      end else if (reg_addr == `BVCS_OFS_RT_RECOVERY) begin
        d.regs.rt_recovery = reg_wdata;
      end else if (reg_addr == `BVCS_OFS_RT_CHECK_TIME) begin
        d.regs.rt_check_time = reg_wdata;
      end else if (reg_addr == `BVCS_OFS_CL_SELECT) begin
        d.regs.cl_select = clampw(reg_wdata, 16'h0000, 16'h0002);
      end else if (reg_addr == `BVCS_OFS_CL_LEVEL) begin
        d.regs.cl_level = clampw(reg_wdata, 16'h00c8, 16'h0708);
      end else if (reg_addr == `BVCS_OFS_QUICK_CL_SELECT) begin
        d.regs.quick_cl_select = clampw(reg_wdata, 16'h0000, 16'h0001);
      end else if (reg_addr == `BVCS_OFS_RT_DECEL_TIME) begin
        d.regs.rt_decel_time = clampw(reg_wdata, 16'h0000, 16'h7530);
      end else if (reg_addr == `BVCS_OFS_HF_COMP) begin
        d.regs.hf_comp = clampw(reg_wdata, 16'h01f4, 16'h0bb8);
      end else if (reg_addr == `BVCS_OFS_OV_BOOST_CEIL) begin
        d.regs.ov_boost_ceil = clampw(reg_wdata, 16'h0000, `BVCS_PERMILLE_FULL);
      end else if (reg_addr == `BVCS_OFS_FW_PROP_GAIN) begin
        d.regs.fw_prop_gain = clampw(reg_wdata, 16'h0000, 16'h1770);
      end else if (reg_addr == `BVCS_OFS_FW_INT_TIME) begin
        d.regs.fw_int_time = clampw(reg_wdata, 16'h0000, 16'h1770);
      end else if (reg_addr == `BVCS_OFS_RAMP_TIME) begin
        d.regs.ramp_time = reg_wdata;
      end
    end

    // Register reads, answered the next cycle
    // Idle and unmapped reads return zero, so a stale word never lingers on the port
    d.rdata = 16'h0000;
    if (reg_read) begin
      if (reg_addr == `BVCS_OFS_BUS_OPTION) begin
        d.rdata = q.regs.bus_option;
      end else if (reg_addr == `BVCS_OFS_OV_THRESHOLD) begin
        d.rdata = q.regs.ov_threshold;
      end else if (reg_addr == `BVCS_OFS_RT_ACTION) begin
        d.rdata = q.regs.rt_action;
      end else if (reg_addr == `BVCS_OFS_RT_RECOVERY) begin
        d.rdata = q.regs.rt_recovery;
      end else if (reg_addr == `BVCS_OFS_RT_CHECK_TIME) begin
        d.rdata = q.regs.rt_check_time;
      end else if (reg_addr == `BVCS_OFS_CL_SELECT) begin
        d.rdata = q.regs.cl_select;
      end else if (reg_addr == `BVCS_OFS_CL_LEVEL) begin
        d.rdata = q.regs.cl_level;
      end else if (reg_addr == `BVCS_OFS_QUICK_CL_SELECT) begin
        d.rdata = q.regs.quick_cl_select;
      end else if (reg_addr == `BVCS_OFS_RT_DECEL_TIME) begin
        d.rdata = q.regs.rt_decel_time;
      end else if (reg_addr == `BVCS_OFS_HF_COMP) begin
        d.rdata = q.regs.hf_comp;
      end else if (reg_addr == `BVCS_OFS_OV_BOOST_CEIL) begin
        d.rdata = q.regs.ov_boost_ceil;
      end else if (reg_addr == `BVCS_OFS_FW_PROP_GAIN) begin
        d.rdata = q.regs.fw_prop_gain;
      end else if (reg_addr == `BVCS_OFS_FW_INT_TIME) begin
        d.rdata = q.regs.fw_int_time;
      end else if (reg_addr == `BVCS_OFS_RAMP_TIME) begin
        d.rdata = q.regs.ramp_time;
      end else if (reg_addr == `BVCS_OFS_STATUS) begin
        d.rdata = {11'h000, q.state, q.power_down, q.ov_active, q.cl_active};
      end else if (reg_addr == `BVCS_OFS_FREQ_OUT) begin
        d.rdata = q.freq;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q                      <= '0;
      q.state                <= bvcs_pkg::st_normal;
      q.regs.bus_option      <= `BVCS_RST_BUS_OPTION;
      q.regs.ov_threshold    <= `BVCS_RST_OV_THRESHOLD;
      q.regs.rt_action       <= `BVCS_RST_RT_ACTION;
      q.regs.rt_recovery     <= `BVCS_RST_RT_RECOVERY;
      q.regs.rt_check_time   <= `BVCS_RST_RT_CHECK_TIME;
      q.regs.cl_select       <= `BVCS_RST_CL_SELECT;
      q.regs.cl_level        <= `BVCS_RST_CL_LEVEL;
      q.regs.quick_cl_select <= `BVCS_RST_QUICK_CL_SELECT;
      q.regs.rt_decel_time   <= `BVCS_RST_RT_DECEL_TIME;
      q.regs.hf_comp         <= `BVCS_RST_HF_COMP;
      q.regs.ov_boost_ceil   <= `BVCS_RST_OV_BOOST_CEIL;
      q.regs.fw_prop_gain    <= `BVCS_RST_FW_PROP_GAIN;
      q.regs.fw_int_time     <= `BVCS_RST_FW_INT_TIME;
      q.regs.ramp_time       <= `BVCS_RST_RAMP_TIME;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata        = q.rdata;
  assign freq_out         = q.freq;
  assign power_down       = q.power_down;
  assign ov_stall_active  = q.ov_active;
  assign cur_limit_active = q.cl_active;
  assign quick_cl_enable  = q.regs.quick_cl_select[0];

endmodule : bus_voltage_current_stall_ctrl
`default_nettype wire

// File: tb/bvcs_plant.sv
`default_nettype none
module bvcs_plant (
  // Bench controls
  input  wire logic [15:0] bus_set,
  input  wire logic [15:0] knee,
  input  wire logic [15:0] heavy,
  // Drive side
  input  wire logic [15:0] freq_out,
  output logic      [15:0] bus_voltage,
  output logic      [15:0] out_current
);
  timeunit 1ns;
  timeprecision 1ps;
  // Load draws heavy current only above the knee, so lowering frequency relieves it
  assign bus_voltage = bus_set;
  assign out_current = (freq_out > knee) ? heavy : 16'h01f4;
endmodule : bvcs_plant
`default_nettype wire

// File: tb/bvcs_asserts.sv
`default_nettype none
module bvcs_checker #(
  parameter int TICK_CYCLES = 100000
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  // Measurements and control
  input wire logic [15:0] bus_voltage,
  input wire logic [15:0] out_current,
  input wire logic        run_cmd,
  input wire logic        vf_mode,
  input wire logic        field_weak,
  // Watched outputs
  input wire logic [15:0] freq_out,
  input wire logic        power_down,
  input wire logic        ov_stall_active,
  input wire logic        cur_limit_active,
  input wire logic        quick_cl_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLAG_WAIT = TICK_CYCLES + 3;
  localparam int REC_MIN   = 98 * TICK_CYCLES;
  // Levels assume default action/recovery/threshold/limit settings
  logic [31:0] low_q;
  logic [31:0] high_q;
  logic [31:0] idle_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_q  <= '0;
      high_q <= '0;
      idle_q <= '0;
    end else begin
      low_q  <= (bus_voltage < 16'h02f8) ? low_q + 1 : '0;
      high_q <= (bus_voltage > 16'h035c) ? high_q + 1 : '0;
      idle_q <= (!vf_mode || !run_cmd) ? idle_q + 1 : '0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_quick_off: assert property (
    reg_write && reg_addr == 12'h70d && reg_wdata == 16'h0000 |-> ##[1:2] !quick_cl_enable)
    else $error("quick limit enable not cleared");
  a_cl_no_vf: assert property (idle_q > FLAG_WAIT |-> !cur_limit_active)
    else $error("current limit active without vf run");
  a_pd_rise: assert property (low_q > FLAG_WAIT |-> power_down)
    else $error("power down missing on low bus");
  a_pd_clear: assert property ($fell(power_down) |-> high_q > REC_MIN)
    else $error("power down cleared before recovery time");
  a_ov_rise: assert property ($rose(ov_stall_active) |-> $past(bus_voltage, 2) > 16'h053d)
    else $error("stall without high bus");
  a_ov_hold: assert property (ov_stall_active [*3] |-> freq_out >= $past(freq_out))
    else $error("frequency fell during stall");
  a_ov_boost: assert property (ov_stall_active [*3] |-> freq_out <= $past(freq_out) + 16'h0001)
    else $error("stall boost too fast");
  a_cl_rise: assert property (
    $rose(cur_limit_active) |-> field_weak || $past(out_current, 2) >= 16'h05dc)
    else $error("current limit without overcurrent");
  a_cl_drop: assert property (
    $fell(cur_limit_active) |-> field_weak || !vf_mode || !run_cmd || $past(out_current, 2) < 16'h05dc)
    else $error("current limit left while overcurrent");
endmodule : bvcs_checker
bind bus_voltage_current_stall_ctrl bvcs_checker #(.TICK_CYCLES(TICK_CYCLES)) bvcs_checker_inst (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .bus_voltage(bus_voltage), .out_current(out_current), .run_cmd(run_cmd), .vf_mode(vf_mode),
  .field_weak(field_weak), .freq_out(freq_out), .power_down(power_down), .ov_stall_active(ov_stall_active),
  .cur_limit_active(cur_limit_active), .quick_cl_enable(quick_cl_enable));
`default_nettype wire

// File: tb/test_bus_voltage_current_stall_ctrl.sv
`default_nettype none
module test_bus_voltage_current_stall_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  localparam logic [27:0] reset_tab [14] = '{28'h706000a, 28'h707053d, 28'h70802f8, 28'h709035c,
    28'h70a0005, 28'h70b0002, 28'h70c05dc, 28'h70d0000, 28'h71e07d0, 28'h7f001f4, 28'h7f10064,
    28'h7f2000f, 28'h7f303e8, 28'h7b00000};
  // Address, written value, value read back
  localparam logic [43:0] clamp_tab [11] = '{44'h70c08000708, 44'h70c05dc05dc, 44'h70b00030002,
    44'h7060003000a, 44'h7070400044c, 44'h707053d053d, 44'h71effff7530, 44'h7f1040003e8,
    44'h71e000a000a, 44'h70a00010001, 44'h7f4000a000a};
  logic        ref_clk, reset, reg_write, reg_read, run_cmd, vf_mode, field_weak;
  logic        power_down, ov_stall_active, cur_limit_active, quick_cl_enable;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, bus_voltage, out_current, freq_ref, freq_out, bus_set, knee, heavy;
  int          n_mismatch = 0;
  int          checked = 0;
  bus_voltage_current_stall_ctrl #(.TICK_CYCLES(T)) bus_voltage_current_stall_ctrl_inst (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_voltage(bus_voltage), .out_current(out_current),
    .freq_ref(freq_ref), .run_cmd(run_cmd), .vf_mode(vf_mode), .field_weak(field_weak), .freq_out(freq_out),
    .power_down(power_down), .ov_stall_active(ov_stall_active), .cur_limit_active(cur_limit_active),
    .quick_cl_enable(quick_cl_enable));
  bvcs_plant bvcs_plant_inst (.bus_set(bus_set), .knee(knee), .heavy(heavy), .freq_out(freq_out),
    .bus_voltage(bus_voltage), .out_current(out_current));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge ref_clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic ticks(input int n);
    repeat (n * T) @(posedge ref_clk);
  endtask : ticks
  // Bounded so a stuck ramp shows up as a mismatch, not a hang
  task automatic settle(input logic [15:0] v);
    for (int i = 0; i < 400 * T && freq_out !== v; i++) @(posedge ref_clk);
  endtask : settle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // Whole sequence needs roughly 20000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [15:0] d;
    logic [15:0] f;
    reset = 1'h1;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    reg_write = 1'h0;
    reg_read = 1'h0;
    freq_ref = 16'h0bb8;
    run_cmd = 1'h1;
    vf_mode = 1'h1;
    field_weak = 1'h0;
    bus_set = 16'h03e8;
    knee = 16'hffff;
    heavy = 16'h0708;
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
    foreach (reset_tab[k]) begin
      rd(reset_tab[k][27:16], d);
      chk("reset value", d, reset_tab[k][15:0]);
    end
    foreach (clamp_tab[k]) begin
      wr(clamp_tab[k][43:32], clamp_tab[k][31:16]);
      rd(clamp_tab[k][43:32], d);
      chk("clamped value", d, clamp_tab[k][15:0]);
    end
    wr(12'h70d, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk("quick on", 16'(quick_cl_enable), 16'h0001);
    wr(12'h70d, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk("quick off", 16'(quick_cl_enable), 16'h0000);
    $display("test registers done");
    wr(12'h706, 16'h000b);
    settle(16'h0bb8);
    bus_set <= 16'h02bc;
    ticks(2);
    chk("power down", 16'(power_down), 16'h0001);
    ticks(20);
    chk("ride decel", 16'(freq_out < 16'h0bb8), 16'h0001);
    bus_set <= 16'h0384;
    ticks(3);
    f = freq_out;
    ticks(40);
    chk("ride hold", freq_out, f);
    chk("power down held", 16'(power_down), 16'h0001);
    rd(12'h7f9, d);
    chk("freq readback", d, f);
    rd(12'h7f8, d);
    chk("status in hold", d, 16'h0014);
    ticks(70);
    chk("power down clear", 16'(power_down), 16'h0000);
    settle(16'h0bb8);
    chk("ride resume", freq_out, 16'h0bb8);
    wr(12'h706, 16'h000c);
    bus_set <= 16'h02bc;
    ticks(2);
    bus_set <= 16'h03e8;
    settle(16'h0000);
    chk("ride stop", freq_out, 16'h0000);
    ticks(120);
    chk("ride stays", freq_out, 16'h0000);
    run_cmd <= 1'h0;
    ticks(3);
    run_cmd <= 1'h1;
    wr(12'h706, 16'h000a);
    settle(16'h0bb8);
    $display("test ride-through done");
    freq_ref <= 16'h03e8;
    ticks(5);
    bus_set <= 16'h0578;
    ticks(2);
    chk("stall on", 16'(ov_stall_active), 16'h0001);
    f = freq_out;
    ticks(10);
    chk("stall hold", 16'(freq_out >= f), 16'h0001);
    chk("stall boost cap", 16'(freq_out <= f + 16'h000a), 16'h0001);
    bus_set <= 16'h03e8;
    settle(16'h03e8);
    chk("stall resume", freq_out, 16'h03e8);
    wr(12'h706, 16'h0000);
    freq_ref <= 16'h0bb8;
    settle(16'h0bb8);
    freq_ref <= 16'h03e8;
    bus_set <= 16'h0578;
    ticks(5);
    chk("stall disabled", 16'(ov_stall_active), 16'h0000);
    chk("decel unheld", 16'(freq_out < 16'h0bb8), 16'h0001);
    bus_set <= 16'h03e8;
    wr(12'h706, 16'h000a);
    freq_ref <= 16'h0bb8;
    settle(16'h0bb8);
    $display("test stall done");
    for (int s = 1; s < 3; s++) begin
      wr(12'h70b, 16'(s));
      knee <= 16'h0000;
      ticks(3);
      chk("limit on", 16'(cur_limit_active), 16'h0001);
      chk("limit lowers", 16'(freq_out < 16'h0bb8), 16'h0001);
      knee <= 16'hffff;
      settle(16'h0bb8);
      ticks(2);
      chk("limit off", 16'(cur_limit_active), 16'h0000);
      chk("limit restore", freq_out, 16'h0bb8);
    end
    wr(12'h70b, 16'h0000);
    knee <= 16'h0000;
    ticks(3);
    chk("limit disabled", 16'(cur_limit_active), 16'h0000);
    wr(12'h70b, 16'h0002);
    vf_mode <= 1'h0;
    ticks(3);
    chk("limit vf only", 16'(cur_limit_active), 16'h0000);
    vf_mode <= 1'h1;
    heavy <= 16'h0320;
    field_weak <= 1'h1;
    ticks(3);
    chk("weak neutral", 16'(cur_limit_active), 16'h0000);
    wr(12'h7f0, 16'h03e8);
    ticks(3);
    chk("weak compensated", 16'(cur_limit_active), 16'h0001);
    knee <= 16'hffff;
    field_weak <= 1'h0;
    wr(12'h7f0, 16'h01f4);
    settle(16'h0bb8);
    $display("test current limit done");
    give_verdict();
  end
endmodule : test_bus_voltage_current_stall_ctrl
`default_nettype wire
